// >>> rtl/sdbm_pkg.sv
package sdbm_pkg;

  // Register byte offsets
  localparam logic [11:0] SDBM_CTRL_OFF = 12'h000;
  localparam logic [11:0] SDBM_MASK_OFF = 12'h004;
  localparam logic [11:0] SDBM_STAT_OFF = 12'h008;

  // Reset values and writable bits; reserved bits read as zero
  localparam logic [31:0] SDBM_CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] SDBM_MASK_RST = 32'h0000_0000;
  localparam logic [31:0] SDBM_CTRL_WMASK = 32'hFFFC_B77C;
  localparam logic [31:0] SDBM_MASK_WMASK = 32'hFFFF_017F;

  // Mask register fields
  localparam int SDBM_BAM_LO = 16;
  localparam int SDBM_WP_BIT = 8;
  localparam int SDBM_CPU_BIT = 6;
  localparam int SDBM_ALT_BIT = 5;
  localparam int SDBM_SC_BIT = 4;
  localparam int SDBM_SD_BIT = 3;
  localparam int SDBM_UC_BIT = 2;
  localparam int SDBM_UD_BIT = 1;
  localparam int SDBM_VALID_BIT = 0;

  // Control register fields
  localparam int SDBM_RE_BIT = 15;
  localparam int SDBM_MRS_BIT = 6;
  localparam int SDBM_IP_BIT = 3;

  typedef enum logic [1:0] {
    SDBM_CMD_NONE,
    SDBM_CMD_ACCESS,
    SDBM_CMD_PRECHARGE,
    SDBM_CMD_MODE
  } sdbm_cmd_t;

  // One processor-side bus cycle offered to the block
  typedef struct packed {
    logic valid;
    logic write;
    logic cpu_space;
    logic alt_master;
    logic supervisor;
    logic code;
    logic [31:0] addr;
  } sdbm_acc_t;

  // Whole state of the block
  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] mask;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic hit;
    logic cmd_valid;
    sdbm_cmd_t cmd;
    logic [10:0] sdram_addr;
    logic [15:0] hit_count;
  } sdbm_state_t;

  // Block hit decision, shared by the datapath and its checks
  function automatic logic sdbm_block_hit(input logic [31:0] ctrl, input logic [31:0] mask,
                                          input sdbm_acc_t acc);
    logic addr_ok;
    logic type_off;
    addr_ok = (((acc.addr[31:16] ^ ctrl[31:16]) & ~mask[31:16]) == 16'h0000);
    type_off = (acc.cpu_space & mask[SDBM_CPU_BIT]) | (acc.alt_master & mask[SDBM_ALT_BIT])
             | (acc.supervisor & acc.code & mask[SDBM_SC_BIT])
             | (acc.supervisor & ~acc.code & mask[SDBM_SD_BIT])
             | (~acc.supervisor & acc.code & mask[SDBM_UC_BIT])
             | (~acc.supervisor & ~acc.code & mask[SDBM_UD_BIT]);
    return acc.valid & mask[SDBM_VALID_BIT] & addr_ok & ~type_off & ~(acc.write & mask[SDBM_WP_BIT]);
  endfunction : sdbm_block_hit

endpackage : sdbm_pkg

// >>> rtl/sdbm_block_map.sv
// Local design decisions: the placing of the registers and the APB register port.
module sdbm_block_map
  import sdbm_pkg::*;
#(
  parameter int ADDR_W = 32
)
(
  // Clock, reset, enable
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Processor bus cycle
  input wire sdbm_acc_t i_acc,
  // SDRAM command side
  output logic o_hit,
  output logic o_cmd_valid,
  output sdbm_cmd_t o_cmd,
  output logic [10:0] o_sdram_addr,
  output logic o_refresh_en
);

  // The compare and mode mapping are written for a 32-bit bus address only
  if (ADDR_W != 32)
  begin : g_bad_width
    $error("sdbm_block_map: ADDR_W must be 32");
  end

  sdbm_state_t s_reg;
  sdbm_state_t s_next;
  logic hit_c;
  logic apb_wr_c;
  logic fire_pre_c;
  logic fire_mode_c;
  logic [10:0] mode_map_c;

  // Hit decision and command selection for the offered cycle
  always_comb
  begin
    hit_c = sdbm_block_hit(s_reg.ctrl, s_reg.mask, i_acc);
    fire_pre_c = hit_c & i_acc.write & s_reg.ctrl[SDBM_IP_BIT];
    fire_mode_c = hit_c & ~fire_pre_c & s_reg.ctrl[SDBM_MRS_BIT];
    apb_wr_c = i_psel & i_penable & i_pwrite & s_reg.pready;
  end

  // Mode value picked off the cycle address, A10 down to A0
  assign mode_map_c = {i_acc.addr[20], i_acc.addr[19], i_acc.addr[18], i_acc.addr[17],
                       i_acc.addr[9], i_acc.addr[10], i_acc.addr[11], i_acc.addr[12],
                       i_acc.addr[13], i_acc.addr[14], i_acc.addr[15]};

  // Next state: bus slave, command issue, arm bit housekeeping
  always_comb
  begin
    s_next = s_reg;
    s_next.hit = hit_c;
    s_next.cmd_valid = hit_c;
    s_next.cmd = SDBM_CMD_NONE;
    if (fire_pre_c)
    begin
      s_next.cmd = SDBM_CMD_PRECHARGE;
      s_next.ctrl[SDBM_IP_BIT] = 1'b0;
    end
    else if (fire_mode_c)
    begin
      s_next.cmd = SDBM_CMD_MODE;
      s_next.sdram_addr = mode_map_c;
      s_next.ctrl[SDBM_MRS_BIT] = 1'b0;
    end
    else if (hit_c)
    begin
      s_next.cmd = SDBM_CMD_ACCESS;
    end
    if (hit_c)
    begin
      s_next.hit_count = s_reg.hit_count + 16'h0001;
    end
    // Answer comes in the first cycle of the access phase; read data is caught at setup
    s_next.pready = 1'b0;
    if (i_psel & ~i_penable)
    begin
      s_next.pready = 1'b1;
      s_next.pslverr = 1'b0;
      if (i_paddr == SDBM_CTRL_OFF)
      begin
        s_next.prdata = s_reg.ctrl;
      end
      else if (i_paddr == SDBM_MASK_OFF)
      begin
        s_next.prdata = s_reg.mask;
      end
      else if (i_paddr == SDBM_STAT_OFF)
      begin
        s_next.prdata = {14'h0000, s_reg.cmd, s_reg.hit_count};
      end
      else
      begin
        s_next.prdata = 32'h0000_0000;
        s_next.pslverr = 1'b1;
      end
    end
    // A software write beats a hardware clear of an arm bit in the same cycle
    if (apb_wr_c && i_paddr == SDBM_CTRL_OFF)
    begin
      s_next.ctrl = i_pwdata & SDBM_CTRL_WMASK;
    end
    else if (apb_wr_c && i_paddr == SDBM_MASK_OFF)
    begin
      s_next.mask = i_pwdata & SDBM_MASK_WMASK;
    end
  end

  // State register; clock enable freezes everything
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      s_reg <= '{ctrl: SDBM_CTRL_RST, mask: SDBM_MASK_RST, prdata: 32'h0000_0000, pready: 1'b0,
                 pslverr: 1'b0, hit: 1'b0, cmd_valid: 1'b0, cmd: SDBM_CMD_NONE,
                 sdram_addr: 11'h000, hit_count: 16'h0000};
    end
    else if (i_ce)
    begin
      s_reg <= s_next;
    end
  end

  // Outputs straight from the state register
  assign o_prdata = s_reg.prdata;
  assign o_pready = s_reg.pready;
  assign o_pslverr = s_reg.pslverr;
  assign o_hit = s_reg.hit;
  assign o_cmd_valid = s_reg.cmd_valid;
  assign o_cmd = s_reg.cmd;
  assign o_sdram_addr = s_reg.sdram_addr;
  assign o_refresh_en = s_reg.ctrl[SDBM_RE_BIT];

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  // A differing unmasked base bit keeps the cycle off the block
  a_unmasked_miss: assert property (i_ce && i_acc.valid &&
    (((i_acc.addr[31:16] ^ s_reg.ctrl[31:16]) & ~s_reg.mask[31:16]) != 16'h0000) |=> !o_hit)
    else $error("unmasked address bit mismatch still hit");

  // Masked bits never decide the hit
  a_masked_ignore: assert property (i_ce && i_acc.valid && s_reg.mask[31:16] == 16'hFFFF &&
    s_reg.mask[SDBM_VALID_BIT] && s_reg.mask[6:1] == 6'h00 && !s_reg.mask[SDBM_WP_BIT] |=> o_hit)
    else $error("fully masked enabled block missed");

  // Without write protect, a matching write is served as a normal access
  a_wp_clear_rw: assert property (i_ce && hit_c && i_acc.write && !s_reg.mask[SDBM_WP_BIT] &&
    !s_reg.ctrl[SDBM_IP_BIT] && !s_reg.ctrl[SDBM_MRS_BIT] |=> o_hit && o_cmd == SDBM_CMD_ACCESS)
    else $error("write refused with write protect clear");

  // CPU-space and alternate master cycles dropped when disabled
  a_space_master_off: assert property (i_ce && ((i_acc.cpu_space && s_reg.mask[SDBM_CPU_BIT]) ||
    (i_acc.alt_master && s_reg.mask[SDBM_ALT_BIT])) |=> !o_hit && !o_cmd_valid)
    else $error("disabled space or master hit the block");

  // Each of the four access types refused by its own bit
  a_type_refused: assert property (i_ce && s_reg.mask[{1'b0, i_acc.supervisor, i_acc.code} + 3'd1]
    |=> !o_hit)
    else $error("disabled access type hit the block");

  // Valid bit clear gates every hit for as long as it stays clear
  a_valid_gate: assert property (i_ce && !s_reg.mask[SDBM_VALID_BIT] |=> !o_hit)
    else $error("hit with valid bit clear");

  sequence s_mode_armed_hit;
    i_ce && fire_mode_c;
  endsequence

  sequence s_mode_issued;
    o_cmd_valid && o_cmd == SDBM_CMD_MODE;
  endsequence

  // Armed cycle becomes a mode load, and only once
  a_mode_once: assert property ((s_mode_armed_hit ##0 !(apb_wr_c && i_paddr == SDBM_CTRL_OFF))
    |=> !s_reg.ctrl[SDBM_MRS_BIT])
    else $error("mode load repeated without rearm");

  a_mode_issue: assert property (s_mode_armed_hit |=> s_mode_issued)
    else $error("armed cycle not turned into a mode load");

  // Mode value pin mapping
  a_mode_addr_map: assert property (s_mode_armed_hit |=> o_sdram_addr == $past(mode_map_c) &&
    o_sdram_addr[10] == $past(i_acc.addr[20]) && o_sdram_addr[6] == $past(i_acc.addr[9]))
    else $error("mode value not mapped from cycle address");

  // Armed precharge: writes turn into precharge-all, reads do not
  a_precharge_wr: assert property (i_ce && hit_c && s_reg.ctrl[SDBM_IP_BIT] && !apb_wr_c
    |=> ((o_cmd == SDBM_CMD_PRECHARGE) == $past(i_acc.write)) && (s_reg.ctrl[SDBM_IP_BIT] != $past(i_acc.write)))
    else $error("precharge command wrong for armed cycle");

  // Refresh enable follows a completed control write
  a_refresh_ctl: assert property (i_ce && apb_wr_c && i_paddr == SDBM_CTRL_OFF
    |=> o_refresh_en == $past(i_pwdata[SDBM_RE_BIT]))
    else $error("refresh enable not taken from control write");

  // Register bus steps shared by the checks below
  sequence s_apb_setup;
    i_ce && i_psel && !i_penable;
  endsequence

  sequence s_apb_write;
    i_ce && apb_wr_c;
  endsequence

  // The answer comes in the first access cycle after every setup
  a_ready_on_setup: assert property (s_apb_setup |=> o_pready)
    else $error("no ready after register setup");

  // Ready is a single-cycle pulse, so the master never sees a stale answer
  a_ready_pulse: assert property (i_ce && o_pready |=> !o_pready)
    else $error("ready held beyond one cycle");

  // Unmapped offsets answer with an error and zero data
  a_unmapped_err: assert property (s_apb_setup ##0 (i_paddr != SDBM_CTRL_OFF &&
    i_paddr != SDBM_MASK_OFF && i_paddr != SDBM_STAT_OFF) |=> o_pslverr && o_prdata == 32'h0000_0000)
    else $error("unmapped offset answered without error");

  // Mapped offsets never flag an error
  a_mapped_ok: assert property (s_apb_setup ##0 (i_paddr == SDBM_CTRL_OFF ||
    i_paddr == SDBM_MASK_OFF || i_paddr == SDBM_STAT_OFF) |=> !o_pslverr)
    else $error("mapped offset flagged an error");

  // Control read data is the register as it stood at setup
  a_ctrl_readback: assert property (s_apb_setup ##0 (i_paddr == SDBM_CTRL_OFF)
    |=> o_prdata == $past(s_reg.ctrl))
    else $error("control read data wrong");

  // Mask read data is the register as it stood at setup
  a_mask_readback: assert property (s_apb_setup ##0 (i_paddr == SDBM_MASK_OFF)
    |=> o_prdata == $past(s_reg.mask))
    else $error("mask read data wrong");

  // A mask write keeps only the implemented bits
  a_mask_write: assert property (s_apb_write ##0 (i_paddr == SDBM_MASK_OFF)
    |=> s_reg.mask == ($past(i_pwdata) & SDBM_MASK_WMASK))
    else $error("mask write not stored");

  // Status is read only; a write there must leave the setup untouched
  a_stat_readonly: assert property (s_apb_write ##0 (i_paddr == SDBM_STAT_OFF)
    |=> $stable(s_reg.mask) && $stable(o_refresh_en))
    else $error("status write changed the setup");

  // Reserved bits can never be set, whatever software writes
  a_reserved_zero: assert property (((s_reg.ctrl & ~SDBM_CTRL_WMASK) == 32'h0000_0000) &&
    ((s_reg.mask & ~SDBM_MASK_WMASK) == 32'h0000_0000))
    else $error("reserved register bit set");

  // Refresh enable moves only with a control write; arm clears never touch it
  a_refresh_hold: assert property (i_ce && !(apb_wr_c && i_paddr == SDBM_CTRL_OFF)
    |=> $stable(o_refresh_en))
    else $error("refresh enable changed without a control write");

  // Clock enable low freezes every bit of state
  a_freeze_hold: assert property (!i_ce |=> $stable(s_reg))
    else $error("state moved with clock enable low");

  // Write protect turns every write into a miss
  a_wp_write_miss: assert property (i_ce && i_acc.valid && i_acc.write && s_reg.mask[SDBM_WP_BIT]
    |=> !o_hit)
    else $error("write hit a write-protected block");

  // Reads are never refused by write protect
  a_read_unprotected: assert property (i_ce && !i_acc.write &&
    sdbm_block_hit(s_reg.ctrl, {s_reg.mask[31:9], 1'b0, s_reg.mask[7:0]}, i_acc) |=> o_hit)
    else $error("read refused by write protect");

  // A miss leaves the command side quiet
  a_miss_quiet: assert property (i_ce && !hit_c
    |=> !o_hit && !o_cmd_valid && o_cmd == SDBM_CMD_NONE)
    else $error("command issued for a miss");

  // Command side: with nothing armed a hit is an ordinary access
  a_plain_access: assert property (i_ce && hit_c && !s_reg.ctrl[SDBM_IP_BIT] &&
    !s_reg.ctrl[SDBM_MRS_BIT] |=> o_cmd == SDBM_CMD_ACCESS)
    else $error("plain hit not served as an access");

  // The precharge arm drops once its write has gone out
  a_pre_arm_clear: assert property (i_ce && fire_pre_c && !(apb_wr_c && i_paddr == SDBM_CTRL_OFF)
    |=> !s_reg.ctrl[SDBM_IP_BIT])
    else $error("precharge arm left set after firing");

  // A pending mode load survives the precharge that goes ahead of it
  a_mode_arm_keep: assert property (i_ce && fire_pre_c && s_reg.ctrl[SDBM_MRS_BIT] &&
    !(apb_wr_c && i_paddr == SDBM_CTRL_OFF) |=> s_reg.ctrl[SDBM_MRS_BIT])
    else $error("mode arm lost to a precharge");

  // The mode value on the address lines holds between mode loads
  a_mode_addr_hold: assert property (i_ce && !fire_mode_c |=> $stable(o_sdram_addr))
    else $error("mode value moved without a mode load");

  // Every hit bumps the status counter by one, wrapping at the top
  a_hit_count: assert property (i_ce && hit_c
    |=> s_reg.hit_count == $past(s_reg.hit_count) + 16'h0001)
    else $error("hit counter did not advance");

endmodule : sdbm_block_map

// >>> verif/sdbm_sdram_model.sv
module sdbm_sdram_model
  import sdbm_pkg::*;
(
  // Commands from the block
  input wire logic i_clk,
  input wire logic i_cmd_valid,
  input wire sdbm_cmd_t i_cmd,
  input wire logic [10:0] i_addr,
  input wire logic i_refresh_en
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [10:0] mode_reg = 11'h000;
  int pre_cnt = 0;
  int order_err = 0;
  // Latch commands; a mode load before precharge and refresh would leave the memory undefined
  always @(posedge i_clk)
  begin
    if (i_cmd_valid && i_cmd == SDBM_CMD_PRECHARGE)
      pre_cnt <= pre_cnt + 1;
    if (i_cmd_valid && i_cmd == SDBM_CMD_MODE)
    begin
      mode_reg <= i_addr;
      if (pre_cnt == 0 || !i_refresh_en)
        order_err <= order_err + 1;
    end
  end
endmodule : sdbm_sdram_model

// >>> verif/tb_sdram_block_map_and_init.sv
module tb_sdram_block_map_and_init
  import sdbm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [31:0] mask;
    logic [4:0] kind;
    logic [31:0] addr;
    logic hit;
  } sdbm_row_t;
  localparam logic [31:0] M = 32'h0074_0075;
  // Kind is write, cpu space, alternate master, supervisor, code
  sdbm_row_t rows [15] = '{'{M, 5'h02, 32'hFF88_0000, 1}, '{M, 5'h03, 32'hFF88_0000, 0},
    '{M, 5'h00, 32'hFF88_0000, 1}, '{M, 5'h01, 32'hFF88_0000, 0}, '{M, 5'h08, 32'hFF88_0000, 0},
    '{M, 5'h04, 32'hFF88_0000, 0}, '{32'h0074_0074, 5'h02, 32'hFF88_0000, 0},
    '{M, 5'h02, 32'hFF98_0000, 1}, '{M, 5'h02, 32'hFF08_0000, 0}, '{M, 5'h12, 32'hFF88_0004, 1},
    '{32'h0074_0175, 5'h12, 32'hFF88_0000, 0}, '{32'h0074_0175, 5'h02, 32'hFF88_0000, 1},
    '{32'h0074_007F, 5'h02, 32'hFF88_0000, 0}, '{32'h0074_007F, 5'h00, 32'hFF88_0000, 0},
    '{32'hFFFF_0001, 5'h00, 32'h1234_0000, 1}};
  logic i_clk = 0, i_rst = 1, i_ce = 1, i_psel = 0, i_penable = 0, i_pwrite = 0;
  logic [11:0] i_paddr = 12'h000;
  logic [31:0] i_pwdata = 32'h0000_0000, o_prdata, rdat;
  logic o_pready, o_pslverr, o_hit, o_cmd_valid, o_refresh_en, rerr;
  sdbm_acc_t i_acc = '0;
  sdbm_cmd_t o_cmd;
  logic [10:0] o_sdram_addr;
  int err_total = 0, n_tests = 0, cyc = 0;
  sdbm_block_map i_dut (.i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
    .o_pslverr(o_pslverr), .i_acc(i_acc), .o_hit(o_hit), .o_cmd_valid(o_cmd_valid), .o_cmd(o_cmd),
    .o_sdram_addr(o_sdram_addr), .o_refresh_en(o_refresh_en));
  sdbm_sdram_model i_mem (.i_clk(i_clk), .i_cmd_valid(o_cmd_valid), .i_cmd(o_cmd), .i_addr(o_sdram_addr),
    .i_refresh_en(o_refresh_en));
  // 125 MHz clock and a hang guard
  always #4 i_clk = ~i_clk;
  always @(posedge i_clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      err_total++;
      results();
    end
  end
  task chk_val(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk_val
  task chk_cmd(input sdbm_cmd_t exp);
    n_tests++;
    if (o_cmd !== exp || o_cmd_valid !== (exp != SDBM_CMD_NONE))
    begin
      err_total++;
      $display("unexpected cmd expected %0d seen %0d", exp, o_cmd);
    end
  endtask : chk_cmd
  // One APB transfer; the request is held until pready is sampled high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge i_clk);
    {i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} <= {2'b10, w, a, d};
    @(posedge i_clk);
    i_penable <= 1'b1;
    do
      @(posedge i_clk);
    while (o_pready !== 1'b1);
    rdat = o_prdata;
    rerr = o_pslverr;
    {i_psel, i_penable} <= 2'b00;
  endtask : apb
  // One processor cycle, outputs looked at half a cycle after they are launched
  task acc(input logic [4:0] k, input logic [31:0] a);
    @(posedge i_clk);
    i_acc <= {1'b1, k, a};
    @(posedge i_clk);
    i_acc <= '0;
    @(negedge i_clk);
  endtask : acc
  task results();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : results
  // Main sequence: register checks, table of hit cases, then the power-up steps
  initial
  begin
    repeat (12) @(posedge i_clk);
    i_rst <= 1'b0;
    apb(0, SDBM_CTRL_OFF, 0);
    chk_val("ctrl", SDBM_CTRL_RST, rdat);
    apb(0, 12'h00C, 0);
    chk_val("slverr", 1, rerr);
    apb(1, SDBM_MASK_OFF, 32'hFFFF_FFFF);
    apb(0, SDBM_MASK_OFF, 0);
    chk_val("mask", SDBM_MASK_WMASK, rdat);
    apb(1, SDBM_CTRL_OFF, 32'hFF88_0300);
    foreach (rows[i])
    begin
      apb(1, SDBM_MASK_OFF, rows[i].mask);
      acc(rows[i].kind, rows[i].addr);
      chk_val("hit", rows[i].hit, o_hit);
      chk_cmd(rows[i].hit ? SDBM_CMD_ACCESS : SDBM_CMD_NONE);
    end
    apb(1, SDBM_MASK_OFF, M);
    // A hitting cycle offered while frozen must leave the outputs alone
    @(posedge i_clk);
    i_ce <= 1'b0;
    acc(5'h02, 32'hFF88_0000);
    chk_val("frozen_hit", 0, o_hit);
    @(posedge i_clk);
    i_ce <= 1'b1;
    apb(1, SDBM_CTRL_OFF, 32'hFF88_0308);
    acc(5'h12, 32'hBEAD_DEED & 32'h0000_0000 | 32'hFF88_0000);
    chk_cmd(SDBM_CMD_PRECHARGE);
    apb(0, SDBM_CTRL_OFF, 0);
    chk_val("ctrl", 32'hFF88_0300, rdat);
    apb(1, SDBM_CTRL_OFF, 32'hFF88_8300);
    @(negedge i_clk);
    chk_val("refresh", 1, o_refresh_en);
    apb(1, SDBM_MASK_OFF, 32'h0068_0075);
    apb(1, SDBM_CTRL_OFF, 32'hFF88_8340);
    acc(5'h02, 32'hFF80_0800);
    chk_cmd(SDBM_CMD_MODE);
    chk_val("sdram_addr", {1'b0, 3'b000, 7'b0010000}, o_sdram_addr);
    chk_val("refresh", 1, o_refresh_en);
    acc(5'h02, 32'hFF80_0800);
    chk_cmd(SDBM_CMD_ACCESS);
    chk_val("order", 0, i_mem.order_err);
    // Six table hits, then precharge, mode load and one access; last command none
    apb(0, SDBM_STAT_OFF, 0);
    chk_val("status", 32'h0000_0009, rdat);
    // Reset in mid-run drops refresh and the mask, so nothing hits afterwards
    @(posedge i_clk);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    @(negedge i_clk);
    chk_val("refresh", 0, o_refresh_en);
    apb(0, SDBM_MASK_OFF, 0);
    chk_val("mask", SDBM_MASK_RST, rdat);
    acc(5'h02, 32'hFF88_0000);
    chk_val("hit", 0, o_hit);
    results();
  end
endmodule : tb_sdram_block_map_and_init
